/* inc/iefr_regs.vh */
`ifndef IEFR_REGS_VH
`define IEFR_REGS_VH

// ---------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------
// flag and enable sit at word indices 6 and 7; one aligned word each, so byte = 4 * index
`define IEFR_PEND_IDX 6
`define IEFR_EN_IDX 7
`define IEFR_PEND_OFS 8'h18
`define IEFR_EN_OFS 8'h1C
`define IEFR_IRQ_STAT_OFS 8'h08
`define IEFR_IRQ_MASK_OFS 8'h0C
`define IEFR_VEC_OFS 8'h10

// ---------------------------------------------
// field positions and reset values
// ---------------------------------------------
`define IEFR_GIE_BIT 7
`define IEFR_TIMER_BIT 4
`define IEFR_I2C_BIT 3
`define IEFR_ADC_BIT 2
`define IEFR_EXT1_BIT 1
`define IEFR_EXT0_BIT 0
`define IEFR_SRC_MASK 8'h1F
`define IEFR_EN_MASK 8'h9F
`define IEFR_PEND_RST 8'h00
`define IEFR_EN_RST 8'h00
`define IEFR_VECTOR 16'h0004
`define IEFR_RESP_OKAY 2'b00
`define IEFR_RESP_SLVERR 2'b10

`endif

/* hdl/iefr_top.v */
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "iefr_regs.vh"

module iefr_top (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire timer_irq_event,
	input wire i2c_irq_event,
	input wire adc_irq_event,
	input wire port_b_pin1_irq_event,
	input wire port_b_pin0_irq_event,
	input wire cpu_irq_ack,
	output wire cpu_irq_req,
	output reg [15:0] cpu_irq_vector,
	output wire irq
);

	// ---------------------------------------------
	// write channel holding registers
	// ---------------------------------------------
	// address and data may arrive in either order; each is held until both are present
	reg aw_held_reg;
	reg [7:0] aw_addr_reg;
	reg w_held_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;
	wire aw_take;
	wire w_take;
	wire b_take;
	wire wr_fire;
	wire [7:0] wr_addr;
	wire [7:0] wr_byte;
	wire wr_lane0;

	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign b_take = s_axi_bvalid && s_axi_bready;
	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign wr_addr = aw_addr_reg;
	assign wr_byte = w_data_reg[7:0];
	assign wr_lane0 = w_strb_reg[0];

	// ---------------------------------------------
	// write address decode
	// ---------------------------------------------
	wire wr_en_sel;
	wire wr_pend_sel;
	wire wr_stat_sel;
	wire wr_mask_sel;
	wire wr_vec_sel;
	wire wr_known;
	wire wr_ok;

	assign wr_en_sel = (wr_addr == `IEFR_EN_OFS);
	assign wr_pend_sel = (wr_addr == `IEFR_PEND_OFS);
	assign wr_stat_sel = (wr_addr == `IEFR_IRQ_STAT_OFS);
	assign wr_mask_sel = (wr_addr == `IEFR_IRQ_MASK_OFS);
	assign wr_vec_sel = (wr_addr == `IEFR_VEC_OFS);
	// the vector register is read-only; a write there is answered but changes nothing
	assign wr_known = wr_en_sel | wr_pend_sel | wr_stat_sel | wr_mask_sel | wr_vec_sel;
	// a write with lane 0 off still gets its response, it just lands nowhere
	assign wr_ok = wr_fire && wr_lane0;

	// ---------------------------------------------
	// write address channel
	// ---------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
		end else if (wr_fire) begin
			aw_held_reg <= 1'b0;
		end else if (aw_take) begin
			aw_held_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
		end
	end

	// ---------------------------------------------
	// write data channel
	// ---------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			w_held_reg <= 1'b0;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
		end else if (wr_fire) begin
			w_held_reg <= 1'b0;
		end else if (w_take) begin
			w_held_reg <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end
	end

	// ---------------------------------------------
	// write response channel
	// ---------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `IEFR_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_known ? `IEFR_RESP_OKAY : `IEFR_RESP_SLVERR;
		end else if (b_take) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ---------------------------------------------
	// enable register
	// ---------------------------------------------
	reg [7:0] irq_enable_mask_reg;
	wire global_irq_enable;
	wire timer_irq_enable;
	wire i2c_irq_enable;
	wire adc_irq_enable;
	wire ext_pin1_irq_enable;
	wire ext_pin0_irq_enable;

	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_enable_mask_reg <= `IEFR_EN_RST;
		end else if (wr_ok && wr_en_sel) begin
			irq_enable_mask_reg <= wr_byte & `IEFR_EN_MASK;
		end
	end

	assign global_irq_enable = irq_enable_mask_reg[`IEFR_GIE_BIT];
	assign timer_irq_enable = irq_enable_mask_reg[`IEFR_TIMER_BIT];
	assign i2c_irq_enable = irq_enable_mask_reg[`IEFR_I2C_BIT];
	assign adc_irq_enable = irq_enable_mask_reg[`IEFR_ADC_BIT];
	assign ext_pin1_irq_enable = irq_enable_mask_reg[`IEFR_EXT1_BIT];
	assign ext_pin0_irq_enable = irq_enable_mask_reg[`IEFR_EXT0_BIT];

	// ---------------------------------------------
	// pending flags
	// ---------------------------------------------
	reg [7:0] irq_pending_flags_reg;
	wire [7:0] irq_pending_flags_next;
	wire [4:0] src_event;
	wire timer_irq_pending;
	wire i2c_irq_pending;
	wire adc_irq_pending;
	wire ext_pin1_irq_pending;
	wire ext_pin0_irq_pending;

	assign src_event = {
		timer_irq_event,
		i2c_irq_event,
		adc_irq_event,
		port_b_pin1_irq_event,
		port_b_pin0_irq_event
	};

	// a set that lands in the same cycle as a software clear survives the clear
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_pend
			if (gi < 5) begin : g_src
				assign irq_pending_flags_next[gi] = src_event[gi] |
					((wr_ok && wr_pend_sel) ? wr_byte[gi] : irq_pending_flags_reg[gi]);
			end else begin : g_unimp
				assign irq_pending_flags_next[gi] = 1'b0;
			end
		end
	endgenerate

	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_pending_flags_reg <= `IEFR_PEND_RST;
		end else begin
			irq_pending_flags_reg <= irq_pending_flags_next;
		end
	end

	assign timer_irq_pending = irq_pending_flags_reg[`IEFR_TIMER_BIT];
	assign i2c_irq_pending = irq_pending_flags_reg[`IEFR_I2C_BIT];
	assign adc_irq_pending = irq_pending_flags_reg[`IEFR_ADC_BIT];
	assign ext_pin1_irq_pending = irq_pending_flags_reg[`IEFR_EXT1_BIT];
	assign ext_pin0_irq_pending = irq_pending_flags_reg[`IEFR_EXT0_BIT];

	// ---------------------------------------------
	// cpu request
	// ---------------------------------------------
	wire [4:0] src_enable;
	wire [4:0] src_pending;
	wire [4:0] src_live;
	wire any_live;

	assign src_enable = {
		timer_irq_enable,
		i2c_irq_enable,
		adc_irq_enable,
		ext_pin1_irq_enable,
		ext_pin0_irq_enable
	};
	assign src_pending = {
		timer_irq_pending,
		i2c_irq_pending,
		adc_irq_pending,
		ext_pin1_irq_pending,
		ext_pin0_irq_pending
	};
	assign src_live = src_pending & src_enable;
	assign any_live = (src_live != 5'h00);
	// global gate on request
	// no priority among sources: the cpu reads the flags to find which one
	assign cpu_irq_req = global_irq_enable && any_live;

	// ---------------------------------------------
	// interrupt vector
	// ---------------------------------------------
	wire vec_load;

	assign vec_load = cpu_irq_ack && cpu_irq_req;

	always @(posedge aclk) begin
		if (!aresetn) begin
			cpu_irq_vector <= 16'h0000;
		end else if (vec_load) begin
			cpu_irq_vector <= `IEFR_VECTOR;
		end
	end

	// ---------------------------------------------
	// block interrupt status and mask
	// ---------------------------------------------
	// flag events mirror into a write-one-to-clear status; keeps software polling apart
	// from the cpu-facing pending flags
	reg [4:0] irq_stat_reg;
	reg [4:0] irq_mask_reg;
	wire [4:0] irq_stat_next;
	wire stat_wr;
	wire [4:0] stat_clr;
	wire [4:0] stat_live;

	assign stat_wr = wr_ok && wr_stat_sel;
	assign stat_clr = stat_wr ? wr_byte[4:0] : 5'h00;

	// set beats a same-cycle write-one clear
	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : g_stat
			assign irq_stat_next[gi] = src_event[gi] | (irq_stat_reg[gi] & ~stat_clr[gi]);
		end
	endgenerate

	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_reg <= 5'h00;
		end else begin
			irq_stat_reg <= irq_stat_next;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask_reg <= 5'h00;
		end else if (wr_ok && wr_mask_sel) begin
			irq_mask_reg <= wr_byte[4:0];
		end
	end

	assign stat_live = irq_stat_reg & irq_mask_reg;
	assign irq = (stat_live != 5'h00);

	// ---------------------------------------------
	// read channel
	// ---------------------------------------------
	reg [31:0] rd_word;
	reg rd_known;
	wire [7:0] rd_addr;
	wire rd_take;
	wire rd_done;

	assign s_axi_arready = !s_axi_rvalid;
	assign rd_addr = s_axi_araddr;
	assign rd_take = s_axi_arvalid && s_axi_arready;
	assign rd_done = s_axi_rvalid && s_axi_rready;

	// readback mux
	// data is captured at the address edge; a flag set while rvalid waits shows next read
	always @* begin
		rd_word = 32'h00000000;
		rd_known = 1'b1;
		case (rd_addr)
			`IEFR_EN_OFS: rd_word[7:0] = irq_enable_mask_reg;
			`IEFR_PEND_OFS: rd_word[7:0] = irq_pending_flags_reg;
			`IEFR_IRQ_STAT_OFS: rd_word[4:0] = irq_stat_reg;
			`IEFR_IRQ_MASK_OFS: rd_word[4:0] = irq_mask_reg;
			`IEFR_VEC_OFS: rd_word[15:0] = cpu_irq_vector;
			default: rd_known = 1'b0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `IEFR_RESP_OKAY;
		end else if (rd_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_known ? `IEFR_RESP_OKAY : `IEFR_RESP_SLVERR;
		end else if (rd_done) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // iefr_top

/* verification/iefr_props.sv */
`timescale 1ns/1ns
module iefr_props (
	input logic aclk, aresetn, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bready,
	input logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
	input logic cpu_irq_ack, cpu_irq_req, irq,
	input logic [1:0] s_axi_bresp,
	input logic [31:0] s_axi_rdata,
	input logic [15:0] cpu_irq_vector
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_vec; cpu_irq_ack && cpu_irq_req |=> cpu_irq_vector == 16'h0004; endproperty
	a_vec: assert property (p_vec) else $error("vector not loaded");
	property p_bw; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_bw: assert property (p_bw) else $error("write taken under bvalid");
	property p_rw; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_rw: assert property (p_rw) else $error("read taken under rvalid");
	property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_bh: assert property (p_bh) else $error("write answer dropped");
	property p_rh; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rh: assert property (p_rh) else $error("read answer dropped");
	property p_ra; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_ra: assert property (p_ra) else $error("read answer late");
	property p_rt; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
	a_rt: assert property (p_rt) else $error("upper read bits set");
	// a request only drops through a register write, flags being sticky
	property p_st; $fell(cpu_irq_req) && $past(aresetn) |-> $rose(s_axi_bvalid); endproperty
	a_st: assert property (p_st) else $error("request dropped alone");
	property p_iq; $fell(irq) && $past(aresetn) |-> $rose(s_axi_bvalid); endproperty
	a_iq: assert property (p_iq) else $error("irq dropped alone");
	c_ack: cover property (cpu_irq_ack && cpu_irq_req);
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
	c_irq: cover property ($rose(irq));
endmodule // iefr_props

/* verification/iefr_cpu_model.sv */
`timescale 1ns/1ns
module iefr_cpu_model (
	input logic aclk,
	input logic aresetn,
	input logic cpu_irq_req,
	input logic ack_en,
	output logic cpu_irq_ack = 1'b0
);
	// take only a raised request
	// pulses, not level, so one acceptance per gap
	always @(posedge aclk) cpu_irq_ack <= aresetn && ack_en && cpu_irq_req && !cpu_irq_ack;
endmodule // iefr_cpu_model

/* verification/testbench.sv */
`timescale 1ns/1ns
`include "iefr_regs.vh"
module testbench;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, ack_en = 0;
	logic [7:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rdv;
	logic [4:0] ev = 0;
	logic [1:0] rs, bs;
	wire awr, wrr, bv, arr, rv, req, ack, irq;
	wire [1:0] br, rr;
	wire [31:0] rdd;
	wire [15:0] vec;
	int failures = 0, checks_done = 0;
	always #10 aclk = ~aclk;
	iefr_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rry), .timer_irq_event(ev[4]), .i2c_irq_event(ev[3]),
		.adc_irq_event(ev[2]), .port_b_pin1_irq_event(ev[1]), .port_b_pin0_irq_event(ev[0]),
		.cpu_irq_ack(ack), .cpu_irq_req(req), .cpu_irq_vector(vec), .irq(irq));
	iefr_cpu_model cpu_u (.aclk(aclk), .aresetn(aresetn), .cpu_irq_req(req), .ack_en(ack_en),
		.cpu_irq_ack(ack));
	task chk(input [31:0] g, input [31:0] e);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// ready is sampled before the edge so the release never races the slave
	task wr(input [7:0] a, input [7:0] d);
		logic ta, tw, tb;
		ta = 0;
		tw = 0;
		awa <= a; wd <= {24'h000000, d}; awv <= 1; wv <= 1; bry <= 1;
		do begin
			@(negedge aclk);
			ta |= awv & awr;
			tw |= wv & wrr;
			tb = bv; bs = br;
			@(posedge aclk);
			if (ta) awv <= 0;
			if (tw) wv <= 0;
		end while (!tb);
		bry <= 0;
		@(posedge aclk);
	endtask
	task rd(input [7:0] a);
		logic ta, tv;
		ta = 0;
		ara <= a; arv <= 1; rry <= 1;
		do begin
			@(negedge aclk);
			ta |= arv & arr;
			tv = rv; rdv = rdd; rs = rr;
			@(posedge aclk);
			if (ta) arv <= 0;
		end while (!tv);
		rry <= 0;
		@(posedge aclk);
	endtask
	task rc(input [7:0] a, input [31:0] e); rd(a); chk(rdv, e); endtask
	task ev_p(input [4:0] m); ev <= m; @(posedge aclk); ev <= 0; @(posedge aclk); endtask
	task t_rst; rc(`IEFR_PEND_OFS, 0);  rc(`IEFR_EN_OFS, 0);
		$display("t_rst done"); endtask
	task t_rw; wr(`IEFR_EN_OFS, 8'hFF); rc(`IEFR_EN_OFS, 32'h9F);
		wr(`IEFR_PEND_OFS, 8'hFF); rc(`IEFR_PEND_OFS, 32'h1F);
		wr(`IEFR_EN_OFS, 8'h00); wr(`IEFR_PEND_OFS, 8'h00); rc(`IEFR_PEND_OFS, 0);
		$display("t_rw done"); endtask
	task t_src; for (int i = 0; i < 5; i++) begin
			ev_p(5'h01 << i); repeat (3) @(posedge aclk);
			rc(`IEFR_PEND_OFS, 32'h1 << i);
			wr(`IEFR_PEND_OFS, 8'h00);
		end $display("t_src done"); endtask
	task t_gate; wr(`IEFR_EN_OFS, 8'h1F); ev_p(5'h04); #1 chk(req, 0);
		wr(`IEFR_EN_OFS, 8'h84); #1 chk(req, 1);
		wr(`IEFR_EN_OFS, 8'h82); #1 chk(req, 0);
		wr(`IEFR_PEND_OFS, 8'h00); $display("t_gate done"); endtask
	task t_vec; wr(`IEFR_EN_OFS, 8'h90); ev_p(5'h10); #1 chk(req, 1);
		ack_en <= 1; repeat (4) @(posedge aclk); ack_en <= 0;
		#1 chk(vec, 16'h0004);
		rc(`IEFR_VEC_OFS, 32'h4);
		wr(`IEFR_PEND_OFS, 8'h00); #1 chk(req, 0);
		wr(`IEFR_EN_OFS, 8'h00); $display("t_vec done"); endtask
	task t_irq; wr(`IEFR_IRQ_MASK_OFS, 8'h01); ev_p(5'h01); #1 chk(irq, 1);
		wr(`IEFR_IRQ_MASK_OFS, 8'h00); #1 chk(irq, 0);
		wr(`IEFR_IRQ_MASK_OFS, 8'h01); wr(`IEFR_IRQ_STAT_OFS, 8'h01); #1 chk(irq, 0);
		chk(bs, `IEFR_RESP_OKAY);
		wr(8'h40, 8'h00); chk(bs, `IEFR_RESP_SLVERR);
		rd(8'h40); chk(rs, `IEFR_RESP_SLVERR); $display("t_irq done"); endtask
	task wrap_up;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		t_rst; t_rw; t_src; t_gate; t_vec; t_irq;
		wrap_up;
	end
	initial begin #100000; failures++; wrap_up; end
endmodule // testbench
bind iefr_top iefr_props u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .cpu_irq_ack(cpu_irq_ack), .cpu_irq_req(cpu_irq_req),
	.irq(irq), .s_axi_bresp(s_axi_bresp), .s_axi_rdata(s_axi_rdata),
	.cpu_irq_vector(cpu_irq_vector));
